// ===== core/dpio_pkg.sv
// Package for the dual port I/O block with system bus multiplex
// Assumes nothing beyond the modules that use it
`default_nettype none
package dpio_pkg;
    localparam int DW = 8;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] THIRD_DIR_IDX = 8'h10;
    localparam logic [7:0] THIRD_DATA_IDX = 8'h11;
    localparam logic [7:0] FOURTH_DIR_IDX = 8'h12;
    localparam logic [7:0] FOURTH_DATA_IDX = 8'h13;
    // Own registers
    localparam logic [7:0] BANK_SEL_IDX = 8'h0f;
    localparam logic [7:0] MODE_IDX = 8'h20;
    localparam logic [7:0] BUS_ADDR_IDX = 8'h21;
    localparam logic [7:0] BUS_WDATA_IDX = 8'h22;
    localparam logic [7:0] BUS_CMD_IDX = 8'h23;
    localparam logic [7:0] BUS_STAT_IDX = 8'h24;
    localparam logic [7:0] DATA_BANK = 8'h01;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;
    // Configuration modes: 0 microprocessor, 1 extended, 2/3 microcontroller
    localparam logic [1:0] MODE_MICROPROC = 2'h0;
    localparam logic [1:0] MODE_EXTENDED = 2'h1;
    localparam logic [1:0] MODE_RESET = 2'h3;
    localparam int CMD_RD_BIT = 0;
    localparam int CMD_WR_BIT = 1;
    localparam int PHASE_NS = 100;
    localparam int CLK_MHZ = 20;
    localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
    typedef enum {BUS_IDLE, BUS_ADDR, BUS_DATA, BUS_DONE} dpio_bus_t;
endpackage
`default_nettype wire

// ===== core/dpio_sync.sv
// Two-stage synchroniser for pin inputs
// Assumes the inputs are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module dpio_sync #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage_q <= '0;
            sync_o <= '0;
        end else begin
            stage_q <= async_i;
            sync_o <= stage_q;
        end
    end
endmodule
`default_nettype wire

// ===== core/dpio_bus_ctrl.sv
// Multiplexed address/data bus sequencer: address phase with latch strobe,
// then a read or write data phase
// Assumes sync pin data from the top and a one-cycle start pulse
`timescale 1ns/1ps
`default_nettype none
module dpio_bus_ctrl #(
    parameter int PHASE = dpio_pkg::PHASE_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic startRd,
    input wire logic startWr,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] pinSync,
    output logic busy,
    output logic [15:0] rdata_q,
    output logic [15:0] adOut_q,
    output logic adOe_q,
    output logic addrLatch_q,
    output logic readEn_b_q,
    output logic writeStrobe_b_q
);
    dpio_pkg::dpio_bus_t state_q;
    logic isRead_q;
    logic [7:0] cnt_q;
    logic last;
    assign last = (cnt_q == 8'(PHASE - 1));
    assign busy = (state_q != dpio_pkg::BUS_IDLE);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= dpio_pkg::BUS_IDLE;
            cnt_q <= 8'h00;
            isRead_q <= 1'b0;
            adOut_q <= 16'h0000;
            adOe_q <= 1'b0;
            addrLatch_q <= 1'b0;
            readEn_b_q <= 1'b1;
            writeStrobe_b_q <= 1'b1;
            rdata_q <= 16'h0000;
        end else begin
            cnt_q <= last ? 8'h00 : cnt_q + 8'h01;
            case (state_q)
                dpio_pkg::BUS_IDLE: begin
                    cnt_q <= 8'h00;
                    if (startRd || startWr) begin
                        state_q <= dpio_pkg::BUS_ADDR;
                        isRead_q <= startRd;
                        adOut_q <= addr;
                        adOe_q <= 1'b1;
                        addrLatch_q <= 1'b1;
                    end
                end
                dpio_pkg::BUS_ADDR: begin
                    if (last) begin
                        state_q <= dpio_pkg::BUS_DATA;
                        addrLatch_q <= 1'b0;
                        adOut_q <= wdata;
                        adOe_q <= !isRead_q;
                        readEn_b_q <= !isRead_q;
                        writeStrobe_b_q <= isRead_q;
                    end
                end
                dpio_pkg::BUS_DATA: begin
                    if (last) begin
                        state_q <= dpio_pkg::BUS_DONE;
                        readEn_b_q <= 1'b1;
                        writeStrobe_b_q <= 1'b1;
                    end
                end
                dpio_pkg::BUS_DONE: begin
                    // Synchroniser lags the pins two cycles, so read data is taken here
                    if (isRead_q) begin
                        rdata_q <= pinSync;
                    end
                    adOe_q <= 1'b0;
                    state_q <= dpio_pkg::BUS_IDLE;
                end
                default: state_q <= dpio_pkg::BUS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== core/dpio_top.sv
// Top of the dual port I/O block with APB register slave
// Assumes APB master on mclk; pins resolved by the bench from the enables
`timescale 1ns/1ps
`default_nettype none
module dpio_top #(
    parameter int PHASE = dpio_pkg::PHASE_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] thirdPinIn,
    output logic [7:0] thirdPinOut,
    output logic [7:0] thirdPinOe,
    input wire logic [7:0] fourthPinIn,
    output logic [7:0] fourthPinOut,
    output logic [7:0] fourthPinOe,
    output logic addrLatch,
    output logic readEn_b,
    output logic writeStrobe_b,
    output logic busMode
);
    logic [7:0] thirdDir_q;
    logic [7:0] thirdLatch_q;
    logic [7:0] fourthDir_q;
    logic [7:0] fourthLatch_q;
    logic [7:0] bankSel_q;
    logic [1:0] mode_q;
    logic [15:0] busAddr_q;
    logic [15:0] busWdata_q;
    logic [7:0] thirdSync;
    logic [7:0] fourthSync;
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;
    logic addrOk;
    logic bankOk;
    logic wrEn;
    logic startRd;
    logic startWr;
    logic busy;
    logic [15:0] busRdata;
    logic [15:0] adOut;
    logic adOe;

    function automatic logic isIdx(input logic [11:0] a, input logic [7:0] idx);
        return (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
    endfunction

    function automatic logic [7:0] pinOe(input logic [7:0] dir);
        return ~dir;
    endfunction

    dpio_sync #(.W(8)) uThirdSync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_i(thirdPinIn),
        .sync_o(thirdSync)
    );

    dpio_sync #(.W(8)) uFourthSync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_i(fourthPinIn),
        .sync_o(fourthSync)
    );

    // Bus mode from configuration
    assign busMode = (mode_q == dpio_pkg::MODE_MICROPROC) || (mode_q == dpio_pkg::MODE_EXTENDED);

    dpio_bus_ctrl #(.PHASE(PHASE)) uBus (
        .mclk(mclk),
        .rst_b(rst_b),
        .startRd(startRd),
        .startWr(startWr),
        .addr(busAddr_q),
        .wdata(busWdata_q),
        .pinSync({fourthSync, thirdSync}),
        .busy(busy),
        .rdata_q(busRdata),
        .adOut_q(adOut),
        .adOe_q(adOe),
        .addrLatch_q(addrLatch),
        .readEn_b_q(readEn_b),
        .writeStrobe_b_q(writeStrobe_b)
    );

    // Pin drive
    always_comb begin
        if (busMode) begin
            thirdPinOut = adOut[7:0];
            fourthPinOut = adOut[15:8];
            thirdPinOe = {8{adOe}};
            fourthPinOe = {8{adOe}};
        end else begin
            thirdPinOut = thirdLatch_q;
            thirdPinOe = pinOe(thirdDir_q);
            fourthPinOut = fourthLatch_q;
            fourthPinOe = pinOe(fourthDir_q);
        end
    end

    // APB: single-cycle access phase, zero wait states
    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite;
    assign bankOk = (bankSel_q == dpio_pkg::DATA_BANK);
    assign addrOk = isIdx(paddr, dpio_pkg::THIRD_DIR_IDX) || isIdx(paddr, dpio_pkg::THIRD_DATA_IDX)
        || isIdx(paddr, dpio_pkg::FOURTH_DIR_IDX) || isIdx(paddr, dpio_pkg::FOURTH_DATA_IDX)
        || isIdx(paddr, dpio_pkg::BANK_SEL_IDX) || isIdx(paddr, dpio_pkg::MODE_IDX)
        || isIdx(paddr, dpio_pkg::BUS_ADDR_IDX) || isIdx(paddr, dpio_pkg::BUS_WDATA_IDX)
        || isIdx(paddr, dpio_pkg::BUS_CMD_IDX) || isIdx(paddr, dpio_pkg::BUS_STAT_IDX);
    assign pslverr = psel && penable && !addrOk;
    assign startWr = wrEn && isIdx(paddr, dpio_pkg::BUS_CMD_IDX) && busMode && !busy
        && pwdata[dpio_pkg::CMD_WR_BIT];
    assign startRd = wrEn && isIdx(paddr, dpio_pkg::BUS_CMD_IDX) && busMode && !busy
        && pwdata[dpio_pkg::CMD_RD_BIT] && !pwdata[dpio_pkg::CMD_WR_BIT];

    // Direction registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            thirdDir_q <= dpio_pkg::DIR_RESET;
            fourthDir_q <= dpio_pkg::DIR_RESET;
        end else if (wrEn && bankOk) begin
            if (isIdx(paddr, dpio_pkg::THIRD_DIR_IDX)) begin
                thirdDir_q <= pwdata[7:0];
            end
            if (isIdx(paddr, dpio_pkg::FOURTH_DIR_IDX)) begin
                fourthDir_q <= pwdata[7:0];
            end
        end
    end

    // Output latches; write touches only the latch
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            thirdLatch_q <= dpio_pkg::LATCH_RESET;
            fourthLatch_q <= dpio_pkg::LATCH_RESET;
        end else if (wrEn && bankOk) begin
            if (isIdx(paddr, dpio_pkg::THIRD_DATA_IDX)) begin
                thirdLatch_q <= pwdata[7:0];
            end
            if (isIdx(paddr, dpio_pkg::FOURTH_DATA_IDX)) begin
                fourthLatch_q <= pwdata[7:0];
            end
        end
    end

    // Bank select, mode and bus request registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bankSel_q <= dpio_pkg::BANK_RESET;
            mode_q <= dpio_pkg::MODE_RESET;
            busAddr_q <= 16'h0000;
            busWdata_q <= 16'h0000;
        end else if (wrEn) begin
            if (isIdx(paddr, dpio_pkg::BANK_SEL_IDX)) begin
                bankSel_q <= pwdata[7:0];
            end
            if (isIdx(paddr, dpio_pkg::MODE_IDX)) begin
                mode_q <= pwdata[1:0];
            end
            if (isIdx(paddr, dpio_pkg::BUS_ADDR_IDX)) begin
                busAddr_q <= pwdata[15:0];
            end
            if (isIdx(paddr, dpio_pkg::BUS_WDATA_IDX)) begin
                busWdata_q <= pwdata[15:0];
            end
        end
    end

    // Read mux; data registers show synchronised pin levels
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (isIdx(paddr, dpio_pkg::THIRD_DIR_IDX) && bankOk) begin
            rdata_d = {24'h000000, thirdDir_q};
        end else if (isIdx(paddr, dpio_pkg::THIRD_DATA_IDX) && bankOk) begin
            rdata_d = {24'h000000, thirdSync};
        end else if (isIdx(paddr, dpio_pkg::FOURTH_DIR_IDX) && bankOk) begin
            rdata_d = {24'h000000, fourthDir_q};
        end else if (isIdx(paddr, dpio_pkg::FOURTH_DATA_IDX) && bankOk) begin
            rdata_d = {24'h000000, fourthSync};
        end else if (isIdx(paddr, dpio_pkg::BANK_SEL_IDX)) begin
            rdata_d = {24'h000000, bankSel_q};
        end else if (isIdx(paddr, dpio_pkg::MODE_IDX)) begin
            rdata_d = {30'h00000000, mode_q};
        end else if (isIdx(paddr, dpio_pkg::BUS_ADDR_IDX)) begin
            rdata_d = {16'h0000, busAddr_q};
        end else if (isIdx(paddr, dpio_pkg::BUS_WDATA_IDX)) begin
            rdata_d = {16'h0000, busWdata_q};
        end else if (isIdx(paddr, dpio_pkg::BUS_STAT_IDX)) begin
            rdata_d = {15'h0000, busy, busRdata};
        end
    end

    // Read data captured in setup phase, stable through access
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= rdata_d;
        end
    end
    assign prdata = prdata_q;
endmodule
`default_nettype wire

// ===== sim/dpio_top_asserts.sv
// Port checker for the dual port I/O top
// Assumes it is bound to dpio_top on the single mclk domain
`timescale 1ns/1ps
`default_nettype none
module dpio_top_asserts #(
    parameter int PHASE = 2
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] thirdPinOut,
    input wire logic [7:0] thirdPinOe,
    input wire logic [7:0] fourthPinOut,
    input wire logic [7:0] fourthPinOe,
    input wire logic addrLatch,
    input wire logic readEn_b,
    input wire logic writeStrobe_b,
    input wire logic busMode
);
    logic [3:0] aleCnt_q;
    logic [3:0] stbCnt_q;
    logic wrSeen_q;
    wire logic stb = !readEn_b || !writeStrobe_b;
    // Phase lengths and first register write since reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aleCnt_q <= 4'h0;
            stbCnt_q <= 4'h0;
            wrSeen_q <= 1'b0;
        end else begin
            aleCnt_q <= addrLatch ? aleCnt_q + 4'h1 : (stb ? 4'h0 : aleCnt_q);
            stbCnt_q <= stb ? stbCnt_q + 4'h1 : (addrLatch ? 4'h0 : stbCnt_q);
            wrSeen_q <= wrSeen_q | (psel && penable && pwrite);
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence sAleEnd;
        $fell(addrLatch);
    endsequence
    sequence sStbEnd;
        $rose(readEn_b) or $rose(writeStrobe_b);
    endsequence
    AST_RST_INPUT: assert property (!wrSeen_q |-> thirdPinOe == 8'h00 && fourthPinOe == 8'h00 && !busMode)
        else $error("pins driven before any write");
    AST_GPIO_QUIET: assert property (!busMode |-> !addrLatch && readEn_b && writeStrobe_b)
        else $error("bus strobes active in port mode");
    AST_BUS_OWN: assert property (busMode |-> thirdPinOe == fourthPinOe && (thirdPinOe == 8'h00 || thirdPinOe == 8'hff))
        else $error("bus mode enables follow port registers");
    AST_ALE_ADDR: assert property (addrLatch && $past(addrLatch) |-> $stable({fourthPinOut, thirdPinOut}) && &thirdPinOe && &fourthPinOe)
        else $error("address not held while latch strobe high");
    AST_ALE_LEN: assert property (sAleEnd |-> aleCnt_q == PHASE && (!readEn_b ^ !writeStrobe_b))
        else $error("latch strobe length or data phase start wrong");
    AST_STB_LEN: assert property (sStbEnd |-> stbCnt_q == PHASE && !addrLatch)
        else $error("read or write strobe length wrong");
    AST_RD_FLOAT: assert property (!readEn_b |-> thirdPinOe == 8'h00 && fourthPinOe == 8'h00)
        else $error("bus driven during read");
    AST_WR_DRIVE: assert property (!writeStrobe_b |-> &thirdPinOe && &fourthPinOe)
        else $error("bus not driven during write");
endmodule
bind dpio_top dpio_top_asserts #(.PHASE(PHASE)) u_asserts (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .thirdPinOut(thirdPinOut), .thirdPinOe(thirdPinOe), .fourthPinOut(fourthPinOut), .fourthPinOe(fourthPinOe),
    .addrLatch(addrLatch), .readEn_b(readEn_b), .writeStrobe_b(writeStrobe_b), .busMode(busMode)
);
`default_nettype wire

// ===== sim/dpio_mem.sv
// Memory model on the multiplexed address/data bus; resolves pin levels
// Assumes the bench gives the level of undriven pins in port mode
`timescale 1ns/1ps
`default_nettype none
module dpio_mem (
    input wire logic mclk,
    input wire logic [7:0] lowOut,
    input wire logic [7:0] lowOe,
    input wire logic [7:0] highOut,
    input wire logic [7:0] highOe,
    input wire logic addrLatch,
    input wire logic readEn_b,
    input wire logic writeStrobe_b,
    input wire logic [15:0] extLevel,
    output logic [7:0] lowPin,
    output logic [7:0] highPin,
    output logic [15:0] lastAddr,
    output logic [15:0] lastData
);
    logic [2:0] rdHold = 3'h0;
    logic [15:0] drv;
    // Read data follows the address and is held a little past the strobe
    assign drv = (!readEn_b || |rdHold) ? lastAddr ^ 16'ha5c3 : extLevel;
    assign lowPin = (lowOut & lowOe) | (drv[7:0] & ~lowOe);
    assign highPin = (highOut & highOe) | (drv[15:8] & ~highOe);
    always @(posedge mclk) begin
        rdHold <= {rdHold[1:0], !readEn_b};
        if (addrLatch) lastAddr <= {highOut, lowOut};
        if (!writeStrobe_b) lastData <= {highOut, lowOut};
    end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the dual port I/O top
// Assumes zero wait state APB and the memory model on the pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %s", $time, m); end end
module tb;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] extLevel = 16'h3cc3;
    logic [31:0] prdata, rd;
    logic pready, pslverr, addrLatch, readEn_b, writeStrobe_b, busMode, err;
    logic [7:0] lowPin, highPin, thirdPinOut, thirdPinOe, fourthPinOut, fourthPinOe;
    logic [15:0] lastAddr, lastData;
    int n_errors = 0;
    int compares = 0;
    always #25 mclk = ~mclk;
    dpio_top #(.PHASE(2)) u_dpio_top (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .thirdPinIn(lowPin),
        .thirdPinOut(thirdPinOut), .thirdPinOe(thirdPinOe), .fourthPinIn(highPin), .fourthPinOut(fourthPinOut),
        .fourthPinOe(fourthPinOe), .addrLatch(addrLatch), .readEn_b(readEn_b), .writeStrobe_b(writeStrobe_b),
        .busMode(busMode)
    );
    dpio_mem u_dpio_mem (
        .mclk(mclk), .lowOut(thirdPinOut), .lowOe(thirdPinOe), .highOut(fourthPinOut), .highOe(fourthPinOe),
        .addrLatch(addrLatch), .readEn_b(readEn_b), .writeStrobe_b(writeStrobe_b), .extLevel(extLevel),
        .lowPin(lowPin), .highPin(highPin), .lastAddr(lastAddr), .lastData(lastData)
    );
    task automatic finish_test();
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        if (n >= 20) finish_test();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitBus();
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h090, 32'h0);
            n++;
        end while (rd[16] !== 1'b0 && n < 50);
        if (n >= 50) n_errors++;
        if (n >= 50) finish_test();
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        apb(1'b0, 12'h040, 32'h0); `CHK(rd, 32'h0, "port reg seen outside bank one");
        apb(1'b1, 12'h03c, 32'h1);
        apb(1'b0, 12'h040, 32'h0); `CHK(rd, 32'hff, "third direction reset");
        apb(1'b0, 12'h048, 32'h0); `CHK(rd, 32'hff, "fourth direction reset");
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 12'h044 + 12'(8 * i), 32'h5a);
            apb(1'b1, 12'h040 + 12'(8 * i), 32'h0f);
            repeat (2) @(posedge mclk);
            apb(1'b0, 12'h044 + 12'(8 * i), 32'h0);
            `CHK(rd[7:0], i ? 8'h5c : 8'h53, "data read not pin levels");
        end
        apb(1'b1, 12'h03c, 32'h0);
        apb(1'b1, 12'h044, 32'h0);
        apb(1'b1, 12'h03c, 32'h1);
        `CHK(thirdPinOut, 8'h5a, "third latch");
        `CHK(thirdPinOe, 8'hf0, "third enables");
        `CHK(fourthPinOut, 8'h5a, "fourth latch");
        `CHK(fourthPinOe, 8'hf0, "fourth enables");
        for (int m = 3; m >= 0; m--) begin
            apb(1'b1, 12'h080, 32'(m));
            @(posedge mclk);
            `CHK(busMode, m < 2, "bus mode select");
            `CHK(thirdPinOe, (m < 2) ? 8'h00 : 8'hf0, "port regs drive pins");
        end
        apb(1'b1, 12'h084, 32'h1234);
        apb(1'b1, 12'h088, 32'hbeef);
        apb(1'b1, 12'h08c, 32'h3);
        waitBus();
        `CHK(lastAddr, 16'h1234, "bus write address");
        `CHK(lastData, 16'hbeef, "bus write data");
        apb(1'b1, 12'h084, 32'h4321);
        apb(1'b1, 12'h08c, 32'h1);
        waitBus();
        `CHK(rd[15:0], 16'he6e2, "bus read data");
        apb(1'b1, 12'h080, 32'h2);
        apb(1'b1, 12'h084, 32'h0055);
        apb(1'b1, 12'h08c, 32'h2);
        apb(1'b0, 12'h090, 32'h0); `CHK(rd[16], 1'b0, "bus cycle in port mode");
        `CHK(lastAddr, 16'h4321, "address sent in port mode");
        apb(1'b0, 12'h100, 32'h0); `CHK({err, rd}, 33'h100000000, "unmapped access");
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        `CHK(thirdPinOe, 8'h00, "enables after reset");
        apb(1'b1, 12'h03c, 32'h1);
        apb(1'b0, 12'h040, 32'h0); `CHK(rd, 32'hff, "direction after reset");
        finish_test();
    end
endmodule
`default_nettype wire
